// ===== tb_top.sv
// Self-checking bench for the timer capture/PWM channel
`timescale 1ns/1ps
`include "tcc_map.svh"
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, v;
	logic pready, pslverr, pin_a_out, pin_a_oe, pin_c_out, pin_c_oe, pin_a, pin_b, er;
	logic [3:0] event_irq;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	int seed = 54744;
	int hi_w, h0, n0, n1, gra, grb;
	int irq_n [4] = '{0, 0, 0, 0};
	realtime ta, tb;
	always #2.5 pclk = ~pclk;
	tcc_channel u_tcc_channel (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.channel0_pin_a(pin_a), .channel0_pin_b(pin_b), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
		.pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe), .event_irq(event_irq));
	tcc_pin_src u_tcc_pin_src (.pclk(pclk), .pin_a_out(pin_a_out), .pin_a(pin_a), .pin_b(pin_b), .hi_cnt(hi_w));
	// ==========================================
	// Request counting and hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < 4; i++) if (event_irq[i] === 1'b1) irq_n[i] <= irq_n[i] + 1;
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			give_verdict();
		end
	end
	// One APB transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Cycles between two pin changes at a 5 ns period
	function automatic logic [31:0] gap(realtime a, realtime b);
		return 32'(int'((b - a) / 5.0));
	endfunction : gap
	function automatic int hi_exp(int a, int b, int k);
		return k * (a - b);
	endfunction : hi_exp
	// Halt, zero the count, configure; start is left to the caller
	task automatic setup(input logic [31:0] ctrl, input logic [3:0] md, input logic [7:0] io, input int a, b);
		apb(1'b1, `TCC_OFS_START, 32'h0);
		apb(1'b1, `TCC_OFS_COUNT, 32'h0);
		apb(1'b1, `TCC_OFS_CTRL, ctrl);
		apb(1'b1, `TCC_OFS_MODE, {28'h0, md});
		apb(1'b1, `TCC_OFS_SYNC, 32'h0);
		apb(1'b1, `TCC_OFS_FILT, 32'h0);
		apb(1'b1, `TCC_OFS_IOH, {24'h0, io});
		apb(1'b1, `TCC_OFS_IOL, {24'h0, io});
		apb(1'b1, `TCC_OFS_GRA, 32'(a));
		apb(1'b1, `TCC_OFS_GRB, 32'(b));
		apb(1'b1, `TCC_OFS_IER, 32'hF);
	endtask : setup
	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	// ==========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `TCC_OFS_GRC, 32'h0);
		chk(rd, 32'h0000FFFF);
		apb(1'b0, 12'h0F0, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		setup({24'h0, `TCC_CLR_CAPT_B, 2'h0, `TCC_PSC_DIV1}, `TCC_MODE_NORMAL,
			{`TCC_IO_CAP_FALL, `TCC_IO_CAP_BOTH}, 32'hFFFF, 32'hFFFF);
		apb(1'b1, `TCC_OFS_START, 32'h1);
		n0 = irq_n[0];
		u_tcc_pin_src.put(1'b1, 1'b1, 8, ta);
		apb(1'b0, `TCC_OFS_GRA, 32'h0);
		v = rd;
		repeat ($unsigned($random(seed)) % 16) @(posedge pclk);
		u_tcc_pin_src.put(1'b0, 1'b1, 8, tb);
		apb(1'b0, `TCC_OFS_GRA, 32'h0);
		chk(rd - v, gap(ta, tb));
		chk(irq_n[0] - n0, 2);
		apb(1'b1, `TCC_OFS_COUNT, 32'h8000);
		n1 = irq_n[1];
		u_tcc_pin_src.put(1'b0, 1'b0, 8, ta);
		apb(1'b0, `TCC_OFS_COUNT, 32'h0);
		chk({31'h0, rd < 32'h20}, 32'h1);
		u_tcc_pin_src.put(1'b0, 1'b1, 8, ta);
		chk(irq_n[1] - n1, 1);
		apb(1'b0, `TCC_OFS_STAT, 32'h0);
		chk(rd & 32'h3, 32'h3);
		apb(1'b1, `TCC_OFS_STAT, 32'h0);
		apb(1'b0, `TCC_OFS_STAT, 32'h0);
		chk(rd & 32'h3, 32'h0);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, `TCC_OFS_FILT, {31'h0, k == 1});
			apb(1'b1, `TCC_OFS_IER, k == 2 ? 32'hE : 32'hF);
			n0 = irq_n[0];
			u_tcc_pin_src.put(1'b1, 1'b1, 1, ta);
			u_tcc_pin_src.put(1'b0, 1'b1, 12, ta);
			chk(irq_n[0] - n0, k == 0 ? 2 : 0);
		end
		apb(1'b1, `TCC_OFS_START, 32'h0);
		apb(1'b0, `TCC_OFS_COUNT, 32'h0);
		v = rd;
		repeat (10) @(posedge pclk);
		apb(1'b0, `TCC_OFS_COUNT, 32'h0);
		chk(rd, v);
		for (int j = 0; j < 2; j++) begin
			gra = 8 + $unsigned($random(seed)) % 40;
			grb = 1 + $unsigned($random(seed)) % (gra - 1);
			setup({24'h0, `TCC_CLR_MATCH_A, 2'h0, `TCC_PSC_DIV1}, `TCC_MODE_PWM1, j ? 8'h25 : 8'h21, gra, grb);
			repeat (8) @(posedge pclk);
			chk({29'h0, pin_c_out, pin_a_oe, pin_a_out}, {29'h0, j[0], 1'b1, j[0]});
			chk({31'h0, pin_c_oe}, 32'h1);
			apb(1'b1, `TCC_OFS_START, 32'h1);
			repeat (3 * (gra + 1)) @(posedge pclk);
			h0 = hi_w;
			n0 = irq_n[0];
			n1 = irq_n[1];
			repeat (4 * (gra + 1)) @(posedge pclk);
			chk(hi_w - h0, hi_exp(gra, grb, 4));
			chk(irq_n[0] - n0 + irq_n[1] - n1, 8);
		end
		give_verdict();
	end
endmodule : tb_top
bind tcc_channel tcc_monitor u_tcc_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pin_a_out(pin_a_out),
	.pin_a_oe(pin_a_oe), .pin_c_oe(pin_c_oe), .event_irq(event_irq));

// ===== tcc_channel.sv
// One 16-bit timer channel with input capture and PWM mode 1, APB slave
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_channel (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic channel0_pin_a,
	input wire logic channel0_pin_b,
	output logic pin_a_out,
	output logic pin_a_oe,
	output logic pin_c_out,
	output logic pin_c_oe,
	output logic [3:0] event_irq
);
	import tcc_pkg::*;

	// ==========================================
	// Registers
	// Every setting sits in its own flop so a write lands in one cycle
	// and the counting logic never sees a half-written field.
	logic count_start_ch0_r;
	logic [2:0] clock_prescale_sel_r;
	logic [2:0] counter_clear_sel_r;
	tcc_code_t channel_mode_sel_r;
	tcc_code_t pin_a_io_code_r, pin_b_io_code_r, pin_c_io_code_r, pin_d_io_code_r;
	logic [3:0] irq_enable_r;
	logic [3:0] event_flag_r;
	logic sync_select_ch0_r;
	logic filter_enable_a_r, filter_enable_b_r;
	tcc_word_t timer_count_r;
	tcc_word_t gr_r [4];
	logic [7:0] psc_cnt_r;
	logic wr_en, rd_en, hit;
	logic tick;
	logic [3:0] ev_capt, ev_match, ev;
	logic clr_now;

	// APB access strobes; every access completes with no wait state
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;

	// ==========================================
	// Pin synchronisers and optional filters
	logic [2:0] sync_a_r, sync_b_r;
	logic [`TCC_FILT_LEN:0] filt_a_r, filt_b_r;
	logic lvl_a_r, lvl_b_r, lvl_a_prev_r, lvl_b_prev_r;
	logic raw_a, raw_b;

	// Pin A: three flops; stages 2 and 3 must agree before a change counts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sync_a_r <= 3'h0;
		else sync_a_r <= {sync_a_r[1:0], channel0_pin_a};
	end

	// Pin B: same three-flop chain as pin A
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sync_b_r <= 3'h0;
		else sync_b_r <= {sync_b_r[1:0], channel0_pin_b};
	end

	// A disagreement between stages 2 and 3 keeps the last accepted level,
	// so a pin that changes near the sampling edge gives one clean step.
	assign raw_a = (sync_a_r[1] == sync_a_r[2]) ? sync_a_r[2] : lvl_a_r;
	assign raw_b = (sync_b_r[1] == sync_b_r[2]) ? sync_b_r[2] : lvl_b_r;

	// Pin A filter: needs a stable run of samples; disabled filter passes straight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_a_r <= '0;
			lvl_a_r <= 1'b0;
			lvl_a_prev_r <= 1'b0;
		end else begin
			filt_a_r <= {filt_a_r[`TCC_FILT_LEN-1:0], sync_a_r[2]};
			if (!filter_enable_a_r) lvl_a_r <= raw_a; // RULE13
			else if (&filt_a_r) lvl_a_r <= 1'b1;
			else if (~|filt_a_r) lvl_a_r <= 1'b0;
			lvl_a_prev_r <= lvl_a_r;
		end
	end

	// Pin B filter: same run length as pin A
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_b_r <= '0;
			lvl_b_r <= 1'b0;
			lvl_b_prev_r <= 1'b0;
		end else begin
			filt_b_r <= {filt_b_r[`TCC_FILT_LEN-1:0], sync_b_r[2]};
			if (!filter_enable_b_r) lvl_b_r <= raw_b; // RULE13
			else if (&filt_b_r) lvl_b_r <= 1'b1;
			else if (~|filt_b_r) lvl_b_r <= 1'b0;
			lvl_b_prev_r <= lvl_b_r;
		end
	end

	// Edge selection from the I/O code of a capture register
	function automatic logic cap_hit(input tcc_code_t code, input logic rise, input logic fall);
		cap_hit = 1'b0;
		case (code)
			`TCC_IO_CAP_BOTH: cap_hit = rise | fall; // RULE8
			`TCC_IO_CAP_FALL: cap_hit = fall; // RULE9
			`TCC_IO_CAP_RISE: cap_hit = rise;
			default: cap_hit = 1'b0;
		endcase
	endfunction : cap_hit

	// ==========================================
	// Prescaler: codes 1 and 2 divide by 4 and 16, codes 3 to 7 divide by 256, code 000b counts every clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) psc_cnt_r <= 8'h00;
		else if (!count_start_ch0_r) psc_cnt_r <= 8'h00;
		else psc_cnt_r <= psc_cnt_r + 8'h01;
	end
	always_comb begin
		case (clock_prescale_sel_r)
			`TCC_PSC_DIV1: tick = count_start_ch0_r; // RULE19 RULE1
			3'h1: tick = count_start_ch0_r & (psc_cnt_r[1:0] == 2'h3);
			3'h2: tick = count_start_ch0_r & (psc_cnt_r[3:0] == 4'hF);
			default: tick = count_start_ch0_r & (psc_cnt_r == 8'hFF);
		endcase
	end

	// ==========================================
	// Capture and compare events per general register
	logic is_normal, is_pwm;
	assign is_normal = channel_mode_sel_r == `TCC_MODE_NORMAL; // RULE4
	assign is_pwm = channel_mode_sel_r == `TCC_MODE_PWM1; // RULE5
	assign ev_capt[0] = is_normal & cap_hit(pin_a_io_code_r, lvl_a_r & ~lvl_a_prev_r, ~lvl_a_r & lvl_a_prev_r);
	assign ev_capt[1] = is_normal & cap_hit(pin_b_io_code_r, lvl_b_r & ~lvl_b_prev_r, ~lvl_b_r & lvl_b_prev_r);
	assign ev_capt[2] = 1'b0;
	assign ev_capt[3] = 1'b0;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_match
			// Compare only when the register is not an input capture
			assign ev_match[gi] = tick & (timer_count_r == gr_r[gi]) & ~ev_capt[gi] // RULE20
				& ~(is_normal & (gi < 2) & ((gi == 0 ? pin_a_io_code_r : pin_b_io_code_r) >= 4'h8));
		end
	endgenerate
	assign ev = ev_capt | ev_match; // RULE17
	assign clr_now = ((counter_clear_sel_r == `TCC_CLR_CAPT_B) & ev_capt[1]) // RULE6
		| ((counter_clear_sel_r == `TCC_CLR_MATCH_A) & ev_match[0]); // RULE7

	// ==========================================
	// Counter: independent channel; a software write presets it and clr_now clears it synchronously
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) timer_count_r <= `TCC_CNT_ZERO;
		else if (wr_en && paddr == `TCC_OFS_COUNT) timer_count_r <= pwdata[15:0];
		else if (clr_now) timer_count_r <= `TCC_CNT_ZERO; // RULE6 RULE7 RULE12
		else if (tick) timer_count_r <= timer_count_r + 16'h0001; // RULE1
	end

	// General registers: software write or capture of the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) gr_r[i] <= 16'hFFFF;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ev_capt[i]) gr_r[i] <= timer_count_r; // RULE8 RULE9
				else if (wr_en && paddr == `TCC_OFS_GRA + 12'(4 * i)) gr_r[i] <= pwdata[15:0];
			end
		end
	end

	// ==========================================
	// Control registers
	// Unmapped offsets match none of these blocks, so a refused write changes nothing.

	// Start bit: clearing it stops the count; only a write or a B capture under clear code 010b still changes the counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) count_start_ch0_r <= 1'b0;
		else if (wr_en && paddr == `TCC_OFS_START) count_start_ch0_r <= pwdata[0]; // RULE1
	end

	// Clock prescale and counter clear selects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_prescale_sel_r <= `TCC_PSC_DIV1;
			counter_clear_sel_r <= `TCC_CLR_NONE;
		end else if (wr_en && paddr == `TCC_OFS_CTRL) begin
			clock_prescale_sel_r <= pwdata[2:0];
			counter_clear_sel_r <= pwdata[7:5];
		end
	end

	// Channel mode select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) channel_mode_sel_r <= `TCC_MODE_NORMAL;
		else if (wr_en && paddr == `TCC_OFS_MODE) channel_mode_sel_r <= pwdata[3:0];
	end

	// I/O codes for registers A and B
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_a_io_code_r <= 4'h0;
			pin_b_io_code_r <= 4'h0;
		end else if (wr_en && paddr == `TCC_OFS_IOH) begin
			pin_a_io_code_r <= pwdata[3:0];
			pin_b_io_code_r <= pwdata[7:4];
		end
	end

	// I/O codes for registers C and D
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_c_io_code_r <= 4'h0;
			pin_d_io_code_r <= 4'h0;
		end else if (wr_en && paddr == `TCC_OFS_IOL) begin
			pin_c_io_code_r <= pwdata[3:0];
			pin_d_io_code_r <= pwdata[7:4];
		end
	end

	// Per-register request enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) irq_enable_r <= 4'h0;
		else if (wr_en && paddr == `TCC_OFS_IER) irq_enable_r <= pwdata[3:0]; // RULE14
	end

	// Sync select is stored only; this channel always counts on its own
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sync_select_ch0_r <= 1'b0;
		else if (wr_en && paddr == `TCC_OFS_SYNC) sync_select_ch0_r <= pwdata[0]; // RULE12
	end

	// Noise filter enables for the two capture pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filter_enable_a_r <= 1'b0;
			filter_enable_b_r <= 1'b0;
		end else if (wr_en && paddr == `TCC_OFS_FILT) begin
			filter_enable_a_r <= pwdata[0];
			filter_enable_b_r <= pwdata[1];
		end
	end

	// Sticky event flags: set wins, write 0 clears a bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) event_flag_r <= 4'h0;
		else if (wr_en && paddr == `TCC_OFS_STAT) event_flag_r <= (event_flag_r & pwdata[3:0]) | ev; // RULE15
		else event_flag_r <= event_flag_r | ev; // RULE15
	end

	// Direct request pulses gated by per-register enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) event_irq <= 4'h0;
		else event_irq <= ev & irq_enable_r; // RULE14 RULE16 RULE17
	end

	// ==========================================
	// PWM mode 1 outputs; code 0000b leaves the output disabled
	function automatic logic io_init(input tcc_code_t code);
		io_init = code[2]; // Codes 01xx start high, 00xx start low
	endfunction : io_init
	function automatic logic io_lvl(input tcc_code_t code, input logic cur);
		case (code[1:0])
			2'h1: io_lvl = 1'b0;
			2'h2: io_lvl = 1'b1;
			2'h3: io_lvl = ~cur;
			default: io_lvl = cur;
		endcase
	endfunction : io_lvl

	// Pin A waveform from the A/B pair; the B code never sets the idle level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_a_out <= 1'b0;
			pin_a_oe <= 1'b0;
		end else begin
			pin_a_oe <= is_pwm & (pin_a_io_code_r != 4'h0); // RULE10
			if (!count_start_ch0_r || !is_pwm) pin_a_out <= io_init(pin_a_io_code_r); // RULE18
			else if (ev_match[1]) pin_a_out <= io_lvl(pin_b_io_code_r, pin_a_out); // RULE11
			else if (ev_match[0]) pin_a_out <= io_lvl(pin_a_io_code_r, pin_a_out); // RULE11
		end
	end

	// Pin C waveform from the C/D pair, same scheme as pin A
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_c_out <= 1'b0;
			pin_c_oe <= 1'b0;
		end else begin
			pin_c_oe <= is_pwm & (pin_c_io_code_r != 4'h0); // RULE10
			if (!count_start_ch0_r || !is_pwm) pin_c_out <= io_init(pin_c_io_code_r); // RULE18
			else if (ev_match[3]) pin_c_out <= io_lvl(pin_d_io_code_r, pin_c_out); // RULE10
			else if (ev_match[2]) pin_c_out <= io_lvl(pin_c_io_code_r, pin_c_out); // RULE10
		end
	end

	// ==========================================
	// APB read data, loaded in setup so it is valid in access phase
	always_comb begin
		hit = 1'b1;
		case (paddr)
			`TCC_OFS_START, `TCC_OFS_CTRL, `TCC_OFS_MODE, `TCC_OFS_IOH, `TCC_OFS_IOL,
			`TCC_OFS_IER, `TCC_OFS_STAT, `TCC_OFS_COUNT, `TCC_OFS_GRA, `TCC_OFS_GRB,
			`TCC_OFS_GRC, `TCC_OFS_GRD, `TCC_OFS_SYNC, `TCC_OFS_FILT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (rd_en) begin
			case (paddr)
				`TCC_OFS_START: prdata <= {31'h0, count_start_ch0_r};
				`TCC_OFS_CTRL: prdata <= {24'h0, counter_clear_sel_r, 2'h0, clock_prescale_sel_r};
				`TCC_OFS_MODE: prdata <= {28'h0, channel_mode_sel_r};
				`TCC_OFS_IOH: prdata <= {24'h0, pin_b_io_code_r, pin_a_io_code_r};
				`TCC_OFS_IOL: prdata <= {24'h0, pin_d_io_code_r, pin_c_io_code_r};
				`TCC_OFS_IER: prdata <= {28'h0, irq_enable_r};
				`TCC_OFS_STAT: prdata <= {28'h0, event_flag_r};
				`TCC_OFS_COUNT: prdata <= {16'h0, timer_count_r};
				`TCC_OFS_GRA: prdata <= {16'h0, gr_r[0]};
				`TCC_OFS_GRB: prdata <= {16'h0, gr_r[1]};
				`TCC_OFS_GRC: prdata <= {16'h0, gr_r[2]};
				`TCC_OFS_GRD: prdata <= {16'h0, gr_r[3]};
				`TCC_OFS_SYNC: prdata <= {31'h0, sync_select_ch0_r};
				`TCC_OFS_FILT: prdata <= {30'h0, filter_enable_b_r, filter_enable_a_r};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Zero wait states: ready rises for the access phase that follows setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pready <= 1'b0;
		else pready <= psel & ~penable;
	end

	// Unmapped or unaligned addresses answer with an error alongside ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pslverr <= 1'b0;
		else pslverr <= psel & ~penable & ~hit;
	end
endmodule : tcc_channel

// ===== tcc_map.svh
// Register offsets, field codes and reset values for the timer capture/PWM channel
// What this block does
// RULE1: Count only while start bit is one
// RULE2: Software halts, zeroes counter, starts last
// RULE3: Software releases module halt before access
// RULE4: Mode 0000b is normal capture/compare mode
// RULE5: Mode 0010b is PWM mode 1
// RULE6: Clear code 010b clears on B capture
// RULE7: Clear code 001b clears on A match
// RULE8: Code 1010b captures on both edges
// RULE9: Code 1001b captures on falling edges only
// RULE10: A/B drive pin A, C/D pin C
// RULE11: Low at A match, high at B match
// RULE12: Sync select zero means independent counting
// RULE13: Filter enable zero passes edges unfiltered
// RULE14: Per-register enable gates its interrupt request
// RULE15: Older flags set on event, cleared by zero
// RULE16: Newer variant sends events straight as requests
// RULE17: Each general register has its own request
// RULE18: PWM initial level from A or C code
// RULE19: Prescale 000b counts every clock
// RULE20: Match when counter equals register value
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// ==========================================
// Register byte offsets
`define TCC_OFS_START 12'h000
`define TCC_OFS_CTRL 12'h004
`define TCC_OFS_MODE 12'h008
`define TCC_OFS_IOH 12'h00C
`define TCC_OFS_IOL 12'h010
`define TCC_OFS_IER 12'h014
`define TCC_OFS_STAT 12'h018
`define TCC_OFS_COUNT 12'h01C
`define TCC_OFS_GRA 12'h020
`define TCC_OFS_GRB 12'h024
`define TCC_OFS_GRC 12'h028
`define TCC_OFS_GRD 12'h02C
`define TCC_OFS_SYNC 12'h030
`define TCC_OFS_FILT 12'h034
// ==========================================
// Field codes
`define TCC_MODE_NORMAL 4'h0
`define TCC_MODE_PWM1 4'h2
`define TCC_CLR_NONE 3'h0
`define TCC_CLR_MATCH_A 3'h1
`define TCC_CLR_CAPT_B 3'h2
`define TCC_PSC_DIV1 3'h0
`define TCC_IO_CAP_BOTH 4'hA
`define TCC_IO_CAP_FALL 4'h9
`define TCC_IO_CAP_RISE 4'h8
`define TCC_CNT_ZERO 16'h0000
`define TCC_FILT_LEN 2'h3
`endif

// ===== tcc_monitor.sv
// Port checker for the timer capture/PWM channel
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pin_a_out,
	input wire logic pin_a_oe,
	input wire logic pin_c_oe,
	input wire logic [3:0] event_irq
);
	// ==========================================
	// Shadow of software settings
	logic wr;
	logic pwm;
	logic st_r;
	logic [3:0] mode_r;
	logic [3:0] ier_r;
	logic [3:0] iol_r;
	logic [7:0] ioh_r;
	logic [2:0] quiet_r;
	assign wr = psel && penable && pwrite && pready && !pslverr;
	assign pwm = mode_r == `TCC_MODE_PWM1;
	// Quiet counts idle cycles since the last write, so latencies settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= 1'b0;
			mode_r <= 4'h0;
			ier_r <= 4'h0;
			iol_r <= 4'h0;
			ioh_r <= 8'h00;
			quiet_r <= 3'h0;
		end else begin
			quiet_r <= wr ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
			if (wr && paddr == `TCC_OFS_START) st_r <= pwdata[0];
			if (wr && paddr == `TCC_OFS_MODE) mode_r <= pwdata[3:0];
			if (wr && paddr == `TCC_OFS_IER) ier_r <= pwdata[3:0];
			if (wr && paddr == `TCC_OFS_IOL) iol_r <= pwdata[3:0];
			if (wr && paddr == `TCC_OFS_IOH) ioh_r <= pwdata[7:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Properties
	apb_answer_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	ready_place_a: assert property (pready |-> psel && penable) else $error("ready outside access");
	err_place_a: assert property (pslverr |-> pready) else $error("error without ready");
	unmapped_err_a: assert property (pready && paddr > 12'h034 |-> pslverr) else $error("unmapped not refused");
	irq_gate_a: assert property (quiet_r == 3'h7 |-> (event_irq & ~ier_r) == 4'h0)
		else $error("masked request seen");
	oe_a_a: assert property (quiet_r == 3'h7 |-> pin_a_oe == (pwm && ioh_r[3:0] != 4'h0))
		else $error("pin a enable wrong");
	oe_c_a: assert property (quiet_r == 3'h7 |-> pin_c_oe == (pwm && iol_r != 4'h0))
		else $error("pin c enable wrong");
	init_level_a: assert property (quiet_r == 3'h7 && pwm && !st_r |-> pin_a_out == ioh_r[2])
		else $error("idle level wrong");
	stop_quiet_a: assert property (pwm && !st_r && quiet_r > 3'h2 |-> event_irq == 4'h0)
		else $error("match while halted");
	fall_match_a: assert property (pwm && st_r && quiet_r == 3'h7 && ioh_r == 8'h21 && ier_r[0] && $fell(pin_a_out)
		|-> ##[0:2] event_irq[0]) else $error("low without a match");
	rise_match_a: assert property (pwm && st_r && quiet_r == 3'h7 && ioh_r == 8'h21 && ier_r[1] && $rose(pin_a_out)
		|-> ##[0:2] event_irq[1]) else $error("high without b match");
	cover property (pwm && st_r && event_irq[0]);
	cover property (!pwm && event_irq[1]);
	cover property (pslverr);
endmodule : tcc_monitor

// ===== tcc_pin_src.sv
// Pulse source on the capture pins and load on the PWM pin
`timescale 1ns/1ps
module tcc_pin_src (
	input wire logic pclk,
	input wire logic pin_a_out,
	output logic pin_a,
	output logic pin_b,
	output int hi_cnt
);
	initial begin
		pin_a = 1'b0;
		pin_b = 1'b1;
		hi_cnt = 0;
	end
	// Load side counts cycles with the waveform high
	always @(posedge pclk) begin
		if (pin_a_out === 1'b1) hi_cnt <= hi_cnt + 1;
	end
	// Set both levels after an edge and hold them for n cycles
	task automatic put(input logic a, input logic b, input int n, output realtime at);
		@(posedge pclk);
		pin_a <= a;
		pin_b <= b;
		at = $realtime;
		repeat (n) @(posedge pclk);
	endtask : put
endmodule : tcc_pin_src

// ===== tcc_pkg.sv
// Types shared by the timer capture/PWM channel
package tcc_pkg;
	typedef logic [15:0] tcc_word_t;
	typedef logic [3:0] tcc_code_t;
endpackage : tcc_pkg
